//--- hwdt_defines.svh
`ifndef HWDT_DEFINES_SVH
`define HWDT_DEFINES_SVH

// ****************************************
// Special function register map
// ****************************************
`define HWDT_KEY_ADDR      8'hA6
`define HWDT_TSEL_ADDR     8'hA7
`define HWDT_KEY_FIRST     8'h1E
`define HWDT_KEY_SECOND    8'hE1
`define HWDT_TSEL_RST      8'h00
`define HWDT_RD_IDLE       8'h00

// ****************************************
// Timeout select fields
// ****************************************
`define HWDT_TSEL_LEN_BIT  3
`define HWDT_TSEL_PS_MSB   2
`define HWDT_TSEL_PS_LSB   0
`define HWDT_TSEL_USED_MSB 3

// ****************************************
// Timing
// ****************************************
`define HWDT_CNT_W         14
`define HWDT_SHORT_W       10
`define HWDT_MC_DIV        6
`define HWDT_PS_W          7
`define HWDT_PULSE_OSC     96

`endif

//--- hwdt_pkg.sv
package hwdt_pkg;

  typedef logic [7:0] hwdt_byte_t;
  typedef logic [2:0] hwdt_psel_t;

  typedef enum logic [0:0] {
    KEY_WAIT_FIRST,
    KEY_WAIT_SECOND
  } hwdt_key_state_t;

endpackage

//--- hwdt_tick_if.sv
`timescale 1ns/10ps

interface hwdt_tick_if;
  import hwdt_pkg::*;

  logic       oscEn;
  hwdt_psel_t prescSel;
  logic       restart;
  logic       wdTick;

  modport div (
    input  oscEn,
    input  prescSel,
    input  restart,
    output wdTick
  );

  modport ctl (
    output oscEn,
    output prescSel,
    output restart,
    input  wdTick
  );
endinterface

//--- hwdt_tick_div.sv
`timescale 1ns/10ps
`include "hwdt_defines.svh"

module hwdt_tick_div #(
  parameter int MC_DIV = `HWDT_MC_DIV,
  parameter int PS_W   = `HWDT_PS_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  hwdt_tick_if.div tk
);
  import hwdt_pkg::*;

  generate
    if (MC_DIV < 2 || MC_DIV > 16 || PS_W < 1 || PS_W > 7) begin : g_chk
      $error("hwdt_tick_div: unsupported divider settings");
    end
  endgenerate

  logic [3:0]      mcCnt_r;
  logic [PS_W-1:0] psCnt_r;
  logic            mcTick;
  logic [PS_W-1:0] psMask;

  // ****************************************
  // Machine cycle divider
  // ****************************************
  assign mcTick = tk.oscEn && (mcCnt_r == 4'(MC_DIV - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mcCnt_r <= '0;
    end else if (tk.restart) begin
      mcCnt_r <= '0;
    end else if (tk.oscEn) begin
      mcCnt_r <= mcTick ? '0 : mcCnt_r + 4'h1;
    end
  end

  // ****************************************
  // Extra prescaler stage
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      psCnt_r <= '0;
    end else if (tk.restart) begin
      psCnt_r <= '0;
    end else if (mcTick) begin
      psCnt_r <= psCnt_r + 1'b1;
    end
  end

  // Select zero passes every machine cycle
  assign psMask    = PS_W'((1 << tk.prescSel) - 1);  // R16
  assign tk.wdTick = mcTick && ((psCnt_r & psMask) == psMask);  // R13
endmodule

//--- hwdt_key_seq.sv
`timescale 1ns/10ps
`include "hwdt_defines.svh"

module hwdt_key_seq (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        clear,
  input wire logic        keyWr,
  input hwdt_pkg::hwdt_byte_t keyData,
  output logic            keyDone
);
  import hwdt_pkg::*;

  hwdt_key_state_t state_r;
  hwdt_key_state_t state_nxt;

  // ****************************************
  // Two byte key detector
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    keyDone   = 1'b0;
    if (keyWr) begin
      case (state_r)
        KEY_WAIT_FIRST: begin
          if (keyData == `HWDT_KEY_FIRST) begin
            state_nxt = KEY_WAIT_SECOND;
          end
        end
        KEY_WAIT_SECOND: begin
          if (keyData == `HWDT_KEY_SECOND) begin
            keyDone   = 1'b1;  // R3
            state_nxt = KEY_WAIT_FIRST;
          end else if (keyData == `HWDT_KEY_FIRST) begin
            state_nxt = KEY_WAIT_SECOND;
          end else begin
            state_nxt = KEY_WAIT_FIRST;  // R15
          end
        end
        default: begin
          state_nxt = KEY_WAIT_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= KEY_WAIT_FIRST;
    end else if (clear) begin
      state_r <= KEY_WAIT_FIRST;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule

//--- hwdt_watchdog.sv
`timescale 1ns/10ps
`include "hwdt_defines.svh"

// Functional notes
// R1 - Supervision timer is a 14-bit up-counter, not readable or writable.
// R2 - After any reset the timer is disabled and does not count.
// R3 - Writing 0x1E then 0xE1 to the key register at 0xA6 arms it.
// R4 - Armed counter advances once per machine cycle of six clock periods.
// R5 - Counter advances only while its oscillator runs, else it holds.
// R6 - Once armed, only hardware reset or overflow disarms it.
// R7 - Overflow length select picks 10-bit or 14-bit counting.
// R8 - Full length overflows on reaching 16383 machine cycles; the code overflows on the 16384th machine cycle, when the count is at 16383.
// R9 - Each completed key sequence restarts the count from zero.
// R10 - Overflow raises the internal chip reset.
// R11 - Overflow drives a high reset pulse of 96 oscillator periods.
// R12 - Key register is write-only; writes only matter as key bytes.
// R13 - A seven-bit prescaler stage extends the timeout.
// R14 - Low-speed crystal option makes the timer use that crystal.
// R15 - 0xE1 not right after 0x1E neither arms nor restarts.
// R16 - Prescaler field is a three-bit select; zero means no division.
module hwdt_watchdog #(
  parameter int CNT_W     = `HWDT_CNT_W,
  parameter int SHORT_W   = `HWDT_SHORT_W,
  parameter int MC_DIV    = `HWDT_MC_DIV,
  parameter int PULSE_OSC = `HWDT_PULSE_OSC
) (
  input wire logic           core_clk,
  input wire logic           nrst,
  input wire logic [7:0]     sfrAddr,
  input hwdt_pkg::hwdt_byte_t sfrWrData,
  input wire logic           sfrWr,
  input wire logic           sfrRd,
  output hwdt_pkg::hwdt_byte_t sfrRdData,
  input wire logic           rcOscTick,
  input wire logic           xtalOscTick,
  input wire logic           lowSpeedXtalSel,
  input wire logic           oscRunning,
  output logic               wdArmed,
  output logic               chipResetReq,
  output logic               resetPinOut,
  output logic               resetPinOe
);
  import hwdt_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_chk_cnt
      $error("hwdt_watchdog: counter width out of range");
    end
    if (SHORT_W < 1 || SHORT_W > CNT_W) begin : g_chk_short
      $error("hwdt_watchdog: short length must fit the counter");
    end
    if (MC_DIV < 2 || MC_DIV > 16) begin : g_chk_div
      $error("hwdt_watchdog: machine cycle divider out of range");
    end
    // Pulse counter is eight bits wide
    if (PULSE_OSC < 1 || PULSE_OSC > 255) begin : g_chk_pulse
      $error("hwdt_watchdog: reset pulse length out of range");
    end
  endgenerate

  // ****************************************
  // Declarations
  // ****************************************
  logic             armed_r;
  logic [CNT_W-1:0] cnt_r;
  hwdt_byte_t       tsel_r;
  hwdt_byte_t       rdData_r;
  logic [7:0]       pulseCnt_r;
  logic             chipRst_r;
  logic             pinOut_r;
  logic             keyWr;
  logic             tselWr;
  logic             keyDone;
  logic             oscTick;
  logic             overflow;
  logic [CNT_W-1:0] limit;
  logic             armed_nxt;
  logic [CNT_W-1:0] cnt_nxt;
  hwdt_byte_t       tsel_nxt;
  hwdt_byte_t       rdData_nxt;
  logic [7:0]       pulseCnt_nxt;
  logic             pulseOn;

  hwdt_tick_if tk ();

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CNT_W-1:0] ovfLimit(input logic shortLen);
    logic [CNT_W-1:0] lim;
    lim = '1;
    if (shortLen) begin
      lim = CNT_W'((1 << SHORT_W) - 1);
    end
    return lim;
  endfunction

  // Full eight-bit match; the bus has no partial decode
  function automatic logic addrHit(input logic [7:0] addr,
                                   input logic [7:0] target);
    return addr == target;
  endfunction

  // Reset stays up until the last counted tick of the pulse has passed
  function automatic logic pulseHigh(input logic       ovf,
                                     input logic [7:0] cnt,
                                     input logic       tick);
    return ovf || (cnt > 8'h01) || (cnt == 8'h01 && !tick);
  endfunction

  // ****************************************
  // Register decode
  // ****************************************
  assign keyWr  = sfrWr && addrHit(sfrAddr, `HWDT_KEY_ADDR);
  assign tselWr = sfrWr && addrHit(sfrAddr, `HWDT_TSEL_ADDR);

  // ****************************************
  // Clock source selection
  // ****************************************
  // Low-speed crystal replaces the RC source when selected
  // Stopped oscillator gives no ticks, so every counter holds
  assign oscTick = (lowSpeedXtalSel ? xtalOscTick : rcOscTick) && oscRunning;  // R14 R5

  // ****************************************
  // Key sequence and machine cycle
  // ****************************************
  // Overflow drops a half-entered key so the restarted chip starts clean
  hwdt_key_seq u_key (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clear    (overflow),
    .keyWr    (keyWr),
    .keyData  (sfrWrData),
    .keyDone  (keyDone)
  );

  assign tk.oscEn    = oscTick;  // R4
  assign tk.prescSel = tsel_r[`HWDT_TSEL_PS_MSB:`HWDT_TSEL_PS_LSB];  // R16
  // Restart also clears the prescaler so no stale phase shortens a period
  assign tk.restart  = keyDone || overflow;  // R9

  hwdt_tick_div #(
    .MC_DIV (MC_DIV),
    .PS_W   (`HWDT_PS_W)
  ) u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tk       (tk)
  );

  // ****************************************
  // Timeout select register
  // ****************************************
  always_comb begin
    tsel_nxt = tsel_r;
    if (overflow) begin
      // Overflow resets the chip, so the select returns to its reset value
      tsel_nxt = `HWDT_TSEL_RST;
    end else if (tselWr) begin
      tsel_nxt = {4'h0, sfrWrData[`HWDT_TSEL_USED_MSB:0]};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tsel_r <= `HWDT_TSEL_RST;
    end else begin
      tsel_r <= tsel_nxt;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Key register reads as zero; it holds nothing readable
  always_comb begin
    rdData_nxt = rdData_r;
    if (sfrRd) begin
      if (addrHit(sfrAddr, `HWDT_TSEL_ADDR)) begin
        rdData_nxt = tsel_r;
      end else begin
        rdData_nxt = `HWDT_RD_IDLE;  // R12
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData_r <= `HWDT_RD_IDLE;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign sfrRdData = rdData_r;

  // ****************************************
  // Arming
  // ****************************************
  always_comb begin
    armed_nxt = armed_r;
    if (overflow) begin
      armed_nxt = 1'b0;  // R6
    end else if (keyDone) begin
      armed_nxt = 1'b1;  // R3
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;  // R2
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // ****************************************
  // Supervision counter
  // ****************************************
  assign limit    = ovfLimit(tsel_r[`HWDT_TSEL_LEN_BIT]);  // R7
  assign overflow = armed_r && tk.wdTick && (cnt_r == limit);  // R8

  always_comb begin
    cnt_nxt = cnt_r;
    if (keyDone || overflow) begin
      cnt_nxt = '0;  // R9
    end else if (armed_r && tk.wdTick) begin
      // Wraps only when short length is selected while the count is past its limit; otherwise overflow clears it first
      cnt_nxt = cnt_r + 1'b1;  // R1 R4
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // Reset generation
  // ****************************************
  // Counts down on oscillator ticks, not core cycles
  always_comb begin
    pulseCnt_nxt = pulseCnt_r;
    if (overflow) begin
      pulseCnt_nxt = 8'(PULSE_OSC);  // R11
    end else if (oscTick && pulseCnt_r != 8'h00) begin
      pulseCnt_nxt = pulseCnt_r - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pulseCnt_r <= '0;
    end else begin
      pulseCnt_r <= pulseCnt_nxt;
    end
  end

  // ****************************************
  // Reset outputs
  // ****************************************
  assign pulseOn = pulseHigh(overflow, pulseCnt_r, oscTick);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chipRst_r <= 1'b0;
    end else begin
      chipRst_r <= pulseOn;  // R10
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinOut_r <= 1'b0;
    end else begin
      pinOut_r <= pulseOn;  // R11
    end
  end

  assign chipResetReq = chipRst_r;
  assign resetPinOut  = pinOut_r;
  assign resetPinOe   = pinOut_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wdArmed <= 1'b0;
    end else begin
      // Drops together with the rise of the reset outputs
      wdArmed <= armed_r && !overflow;
    end
  end
endmodule

//--- hwdt_watchdog_sva.sv
`timescale 1ns/10ps
module hwdt_watchdog_sva #(
  parameter int PULSE_OSC = 96
) (
  input wire logic            core_clk,
  input wire logic            nrst,
  input wire logic [7:0]      sfrAddr,
  input hwdt_pkg::hwdt_byte_t sfrWrData,
  input wire logic            sfrWr,
  input wire logic            sfrRd,
  input hwdt_pkg::hwdt_byte_t sfrRdData,
  input wire logic            rcOscTick,
  input wire logic            xtalOscTick,
  input wire logic            lowSpeedXtalSel,
  input wire logic            oscRunning,
  input wire logic            wdArmed,
  input wire logic            chipResetReq,
  input wire logic            resetPinOut,
  input wire logic            resetPinOe
);
  import hwdt_pkg::*;
  logic [7:0] pulseCnt_r;
  logic       selTick;
  assign selTick = oscRunning && (lowSpeedXtalSel ? xtalOscTick : rcOscTick);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // Oscillator ticks seen during the pulse
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pulseCnt_r <= 8'h00;
    end else if (!resetPinOut) begin
      pulseCnt_r <= 8'h00;
    end else if (selTick) begin
      pulseCnt_r <= pulseCnt_r + 8'h01;
    end
  end
  a_pin_oe_match: assert property (resetPinOe == resetPinOut)
    else $error("pin enable differs from pin value");
  a_pin_chip_same: assert property (chipResetReq == resetPinOut)
    else $error("chip reset and pin pulse differ");
  a_pulse_disarms: assert property ($rose(chipResetReq) |-> !wdArmed)
    else $error("still armed during reset pulse");
  a_disarm_cause: assert property ($fell(wdArmed) |-> ##[0:2] chipResetReq)
    else $error("disarmed without overflow");
  a_key_arms: assert property ((sfrWr && sfrAddr == 8'hA6 && sfrWrData == 8'h1E) ##1 !sfrWr
    ##1 (sfrWr && sfrAddr == 8'hA6 && sfrWrData == 8'hE1) |-> ##[1:3] wdArmed)
    else $error("key sequence did not arm");
  a_idle_unarmed: assert property ((!wdArmed && !sfrWr)[*4] |=> !wdArmed)
    else $error("armed without key");
  a_stall_holds: assert property ((!oscRunning)[*2] |-> !$rose(chipResetReq))
    else $error("overflow while oscillator stopped");
  a_pulse_width: assert property ($fell(resetPinOut) |->
    pulseCnt_r >= PULSE_OSC - 1 && pulseCnt_r <= PULSE_OSC + 1)
    else $error("reset pulse width wrong");
  a_key_reads_zero: assert property (sfrRd && sfrAddr == 8'hA6 |=> sfrRdData == 8'h00)
    else $error("key register readable");
  a_tsel_upper_zero: assert property (sfrRd && sfrAddr == 8'hA7 |=> sfrRdData[7:4] == 4'h0)
    else $error("timeout select upper bits set");
endmodule

bind hwdt_watchdog hwdt_watchdog_sva #(.PULSE_OSC(PULSE_OSC)) u_sva (.core_clk, .nrst,
  .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .rcOscTick, .xtalOscTick,
  .lowSpeedXtalSel, .oscRunning, .wdArmed, .chipResetReq, .resetPinOut, .resetPinOe);

//--- hardware_watchdog_timer_bench.sv
`timescale 1ns/10ps
`define CMP(a, b, m) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module hardware_watchdog_timer_bench;
  import hwdt_pkg::*;
  localparam int CW = 6;
  localparam int SW = 4;
  logic       core_clk = 0;
  logic       nrst = 0;
  logic [7:0] sfrAddr = 8'h00;
  hwdt_byte_t sfrWrData = 8'h00;
  hwdt_byte_t sfrRdData;
  logic       sfrWr = 0;
  logic       sfrRd = 0;
  logic       rcOscTick = 0;
  logic       xtalOscTick = 0;
  logic       lowSpeedXtalSel = 0;
  logic       oscRunning = 1;
  logic       wdArmed;
  logic       chipResetReq;
  logic       resetPinOut;
  logic       resetPinOe;
  int         error_cnt = 0;
  int         checks = 0;
  int         tickCnt = 0;
  hwdt_watchdog #(.CNT_W(CW), .SHORT_W(SW), .PULSE_OSC(4)) dut (.core_clk, .nrst, .sfrAddr,
    .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .rcOscTick, .xtalOscTick, .lowSpeedXtalSel,
    .oscRunning, .wdArmed, .chipResetReq, .resetPinOut, .resetPinOe);
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    rcOscTick <= 1'($urandom % 2);
    xtalOscTick <= 1'($urandom % 2);
  end
  // Ticks of the selected oscillator, the timer's time base
  always @(posedge core_clk) begin
    if (oscRunning && (lowSpeedXtalSel ? xtalOscTick : rcOscTick)) tickCnt++;
  end
  task automatic special_function_register(input logic [7:0] a, input hwdt_byte_t d, input logic rd);
    @(negedge core_clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = ~rd;
    sfrRd = rd;
    @(negedge core_clk);
    sfrWr = 0;
    sfrRd = 0;
  endtask
  task automatic rdChk(input logic [7:0] a, input hwdt_byte_t e);
    special_function_register(a, 8'h00, 1);
    @(negedge core_clk);
    `CMP(sfrRdData, e, "read data")
  endtask
  task automatic key();
    special_function_register(8'hA6, 8'h1E, 0);
    special_function_register(8'hA6, 8'hE1, 0);
  endtask
  task automatic waitSig(input logic v);
    int n;
    n = 0;
    while (chipResetReq !== v && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic runOvf(input hwdt_byte_t ts, input bit svc, input bit stall);
    int e;
    int n;
    e = ((1 << (ts[3] ? SW : CW)) << ts[2:0]) * 6;
    special_function_register(8'hA7, ts, 0);
    key();
    tickCnt = 0;
    if (stall) begin
      oscRunning = 0;
      repeat (2 * e) @(negedge core_clk);
      oscRunning = 1;
    end
    `CMP(chipResetReq, 1'b0, "overflow while stopped")
    n = 0;
    while (tickCnt < e / 4 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    special_function_register(8'hA6, 8'h55, 0);
    special_function_register(8'hA6, 8'hE1, 0);
    `CMP(wdArmed, 1'b1, "disarmed by write")
    if (svc) begin
      key();
      tickCnt = 0;
    end
    waitSig(1'b1);
    `CMP(tickCnt >= e - 2 && tickCnt <= e + 2, 1'b1, "overflow time")
    `CMP(resetPinOut, 1'b1, "no pin pulse")
    `CMP(wdArmed, 1'b0, "armed after overflow")
    waitSig(1'b0);
    rdChk(8'hA7, 8'h00);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    int s;
    s = $urandom(39);
    repeat (2) @(negedge core_clk);
    nrst = 1;
    `CMP(wdArmed, 1'b0, "armed after reset")
    `CMP(resetPinOe, 1'b0, "pin driven")
    rdChk(8'hA7, 8'h00);
    special_function_register(8'hA7, 8'hFF, 0);
    rdChk(8'hA7, 8'h0F);
    special_function_register(8'hA5, 8'h3C, 0);
    rdChk(8'hA5, 8'h00);
    rdChk(8'hA6, 8'h00);
    special_function_register(8'hA6, 8'hE1, 0);
    repeat (4) @(negedge core_clk);
    `CMP(wdArmed, 1'b0, "lone second key armed")
    for (int i = 0; i < 8; i++) begin
      lowSpeedXtalSel = (i == 3);
      runOvf(i == 0 ? 8'h00 : i == 1 ? 8'h08 :
        {4'h0, 1'($urandom % 2), 3'($urandom % 3)}, i == 2, i == 1);
    end
    print_verdict();
  end
  initial begin
    #600000;
    error_cnt++;
    print_verdict();
  end
endmodule
